// file: bus_sizer_map.svh
// Constants for the dynamic bus sizing sequencer
`ifndef BUS_SIZER_MAP_SVH
`define BUS_SIZER_MAP_SVH

`define SIZE_CODE_LONG      2'h0
`define SIZE_CODE_BYTE      2'h1
`define SIZE_CODE_WORD      2'h2
`define SIZE_CODE_THREE     2'h3

`define ACK_PORT_32         2'h0
`define ACK_PORT_16         2'h1
`define ACK_PORT_8          2'h2
`define ACK_NONE            2'h3

`define STROBE_RESET_N      1'h1
`define RW_RESET_READ       1'h1
`define DATA_RESET          32'h0000_0000

`endif

// file: bus_sizer_pkg.sv
// Types for the dynamic bus sizing sequencer
`default_nettype none
package bus_sizer_pkg;

    typedef logic [1:0] size_code_t;

    typedef enum logic [1:0]
    {
        S_IDLE,
        S_ADDR,
        S_WAIT,
        S_END
    } seq_state_e;

    typedef struct packed
    {
        logic [31:0] addr;
        size_code_t  size;
        logic        write;
        logic        fetch;
        logic [31:0] wdata;
    } op_req_s;

endpackage : bus_sizer_pkg
`default_nettype wire

// file: bus_sizer.sv
// Processor bus sequencer splitting operands by the port width the port reports
`timescale 1ns/1ps
`include "bus_sizer_map.svh"
`default_nettype none

// Function
// R1 - External logic decodes size code and two low address bits into lane strobes.
// R2 - Size code carries bytes still to move: 01 byte, 10 word, 11 three, 00 long.
// R3 - Operand's most significant byte sits on the lane picked by the low address bits.
// R4 - Sixteen-bit ports sit on the upper two lanes, eight-bit ports on the top lane.
// R5 - Wide ports get one strobe per lane so untouched bytes stay intact.
// R6 - Eight-bit ports may use data or address strobe directly as select.
// R7 - Each port returns its real width on the two width acknowledge inputs.
// R8 - Transfers split into as many bus cycles as the reported port width needs.
// R9 - Long write to odd address on sixteen-bit port takes three cycles.
// R10 - Instruction fetches are long aligned; data may have any size and alignment.
// R11 - Cachable reads get valid data on every lane of the reported width.
// R12 - Lane strobes include read/write so reads enable all lanes.
// R13 - Lane strobes are active low, combinational and negated outside bus cycles.
module bus_sizer
(
    input  wire logic                  core_clk,           // System clock, 25 MHz
    input  wire logic                  reset,              // Asynchronous reset, active high
    input  wire bus_sizer_pkg::op_req_s req,               // Operand request
    input  wire logic                  req_valid,          // Request present
    output logic                       req_ready,          // Sequencer idle, takes request
    output logic                       rsp_valid,          // One-cycle pulse, operand done
    output logic [31:0]                rsp_rdata,          // Read operand, right justified
    output logic [31:0]                bus_addr,           // Address of the current bus cycle
    output logic                       size_code_high,     // Remaining byte count, high bit
    output logic                       size_code_low,      // Remaining byte count, low bit
    output logic                       read_write,         // High for read, low for write
    output logic                       address_strobe_n,   // Address strobe, active low
    output logic                       data_strobe_n,      // Data strobe, active low
    output logic [31:0]                data_out,           // Data bus output
    output logic                       data_oe,            // Data bus output enable
    input  wire logic [31:0]           data_in,            // Data bus input
    input  wire logic                  port_width_ack_high_n, // Width acknowledge high, active low
    input  wire logic                  port_width_ack_low_n   // Width acknowledge low, active low
);

    bus_sizer_pkg::seq_state_e state_q;
    bus_sizer_pkg::seq_state_e state_d;
    logic [2:0]  rem_q;
    logic [31:0] addr_q;
    logic [31:0] op_q;
    logic [31:0] res_q;
    logic        write_q;
    logic        addr_stb_n_q;
    logic        data_stb_n_q;
    logic [31:0] wdata_q;
    logic        oe_q;
    logic        rsp_valid_q;
    logic [1:0]  ack_m_q;
    logic [1:0]  ack_s_q;
    logic [31:0] rd_m_q;
    logic [31:0] rd_s_q;

    // Synchronisers for the asynchronous port answers
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ack_m_q <= `ACK_NONE;
            ack_s_q <= `ACK_NONE;
            rd_m_q  <= `DATA_RESET;
            rd_s_q  <= `DATA_RESET;
        end
        else
        begin
            ack_m_q <= {port_width_ack_high_n, port_width_ack_low_n};
            ack_s_q <= ack_m_q;
            rd_m_q  <= data_in;
            rd_s_q  <= rd_m_q;
        end
    end

    wire logic [1:0]  off       = addr_q[1:0];
    wire logic        ack_seen  = ack_s_q != `ACK_NONE;
    wire logic        port32    = ack_s_q == `ACK_PORT_32;
    wire logic        port16    = ack_s_q == `ACK_PORT_16;
    wire logic        req_fire  = req_valid && (state_q == bus_sizer_pkg::S_IDLE);
    wire logic        take      = (state_q == bus_sizer_pkg::S_WAIT) && ack_seen;
    wire logic [2:0]  req_bytes = {req.size == `SIZE_CODE_LONG, req.size};
    wire logic [5:0]  wr_shift  = {3'h4 - req_bytes, 3'h0};

    // Bytes that fit this cycle, by reported width
    wire logic [2:0]  room  = port32 ? 3'h4 - {1'b0, off}
                            : port16 ? 3'h2 - {2'h0, off[0]} : 3'h1;          // see R8
    wire logic [2:0]  n     = (rem_q < room) ? rem_q : room;
    wire logic [5:0]  sh    = {n, 3'h0};
    wire logic [31:0] align = port32 ? rd_s_q << {off, 3'h0}
                            : port16 ? {rd_s_q[31:16], 16'h0} << {off[0], 3'h0}
                            : {rd_s_q[31:24], 24'h0};
    wire logic [31:0] res_next = (res_q << sh) | (align >> (6'h20 - sh));
    wire logic        last     = (rem_q == n);

    // Lane multiplexer: MSB on addressed lane, duplicated for narrow ports
    wire logic [31:0] lanes =
    {
        op_q[31:24],                                                      // see R3
        off[0] ? op_q[31:24] : op_q[23:16],
        (off == 2'h0) ? op_q[15:8] : (off == 2'h1) ? op_q[23:16] : op_q[31:24],
        (off == 2'h0) ? op_q[7:0] : (off == 2'h1) ? op_q[15:8]
                      : (off == 2'h2) ? op_q[23:16] : op_q[31:24]
    };

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            bus_sizer_pkg::S_IDLE: if (req_valid) state_d = bus_sizer_pkg::S_ADDR;
            bus_sizer_pkg::S_ADDR: state_d = bus_sizer_pkg::S_WAIT;
            bus_sizer_pkg::S_WAIT: if (ack_seen) state_d = bus_sizer_pkg::S_END;
            bus_sizer_pkg::S_END:
                if (!ack_seen)
                    state_d = (rem_q == 3'h0) ? bus_sizer_pkg::S_IDLE : bus_sizer_pkg::S_ADDR;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            state_q <= bus_sizer_pkg::S_IDLE;
        else
            state_q <= state_d;
    end

    // Operand bookkeeping
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rem_q   <= 3'h0;
            addr_q  <= 32'h0;
            op_q    <= 32'h0;
            res_q   <= 32'h0;
            write_q <= 1'b0;
        end
        else if (req_fire)
        begin
            rem_q   <= req.fetch ? 3'h4 : req_bytes;                          // see R2, R10
            addr_q  <= req.fetch ? {req.addr[31:2], 2'h0} : req.addr;         // see R10
            op_q    <= req.wdata << wr_shift;
            res_q   <= 32'h0;
            write_q <= req.write && !req.fetch;
        end
        else if (take)
        begin
            rem_q  <= rem_q - n;                                              // see R8, R9
            addr_q <= addr_q + {29'h0, n};
            op_q   <= op_q << sh;
            res_q  <= res_next;
        end
    end

    // Pin drivers
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            addr_stb_n_q <= `STROBE_RESET_N;
            data_stb_n_q <= `STROBE_RESET_N;
            wdata_q <= `DATA_RESET;
            oe_q    <= 1'b0;
        end
        else
        begin
            addr_stb_n_q <= !(state_d == bus_sizer_pkg::S_ADDR || state_d == bus_sizer_pkg::S_WAIT);
            data_stb_n_q <= !(state_d == bus_sizer_pkg::S_WAIT);
            oe_q    <= write_q && (state_q == bus_sizer_pkg::S_ADDR || (state_q == bus_sizer_pkg::S_WAIT && !ack_seen));
            if (state_q == bus_sizer_pkg::S_ADDR)
                wdata_q <= lanes;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rsp_valid_q <= 1'b0;
            rsp_rdata   <= `DATA_RESET;
        end
        else
        begin
            rsp_valid_q <= (state_q == bus_sizer_pkg::S_END) && !ack_seen && (rem_q == 3'h0);
            if (take && last)
                rsp_rdata <= res_next;
        end
    end

    assign req_ready        = state_q == bus_sizer_pkg::S_IDLE;
    assign rsp_valid        = rsp_valid_q;
    assign bus_addr         = addr_q;
    assign size_code_high   = rem_q[1];                                       // see R2
    assign size_code_low    = rem_q[0];
    assign read_write       = !write_q;
    assign address_strobe_n = addr_stb_n_q;
    assign data_strobe_n    = data_stb_n_q;
    assign data_out         = wdata_q;
    assign data_oe          = oe_q;

    // Checking helpers: cycles per operand and whether all came from 16-bit ports
    logic [2:0] cyc_q;
    logic       only16_q;
    logic       long_odd_q;
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cyc_q      <= 3'h0;
            only16_q   <= 1'b0;
            long_odd_q <= 1'b0;
        end
        else if (req_fire)
        begin
            cyc_q      <= 3'h0;
            only16_q   <= 1'b1;
            long_odd_q <= req.write && !req.fetch && req.size == `SIZE_CODE_LONG && req.addr[0];
        end
        else if (take)
        begin
            cyc_q    <= cyc_q + 3'h1;
            only16_q <= only16_q && port16;
        end
    end

    sequence seq_first_addr;
        state_q == bus_sizer_pkg::S_ADDR;
    endsequence

    chk_size_code_start: assert property (@(posedge core_clk) disable iff (reset) // see R2
        req_fire && !req.fetch |=> seq_first_addr ##0 ({size_code_high, size_code_low} == $past(req.size)))
        else $error("size code does not match requested size");

    chk_fetch_long_aligned: assert property (@(posedge core_clk) disable iff (reset) // see R10
        req_fire && req.fetch |=> bus_addr[1:0] == 2'h0 && {size_code_high, size_code_low} == `SIZE_CODE_LONG)
        else $error("instruction fetch not long aligned");

    chk_byte_port_step: assert property (@(posedge core_clk) disable iff (reset) // see R8
        take && ack_s_q == `ACK_PORT_8 |=> rem_q == $past(rem_q) - 3'h1 && bus_addr == $past(bus_addr) + 32'h1)
        else $error("byte port did not advance by one byte");

    chk_msb_top_lane: assert property (@(posedge core_clk) disable iff (reset) // see R3
        state_q == bus_sizer_pkg::S_ADDR && write_q |=> data_out[31:24] == $past(op_q[31:24]) && data_oe)
        else $error("operand msb missing from top lane");

    chk_three_cycle_write: assert property (@(posedge core_clk) disable iff (reset) // see R9
        rsp_valid && long_odd_q && only16_q |-> cyc_q == 3'h3)
        else $error("odd long write on 16-bit port not three cycles");

    chk_strobe_order: assert property (@(posedge core_clk) disable iff (reset) // see R8
        $fell(data_strobe_n) |-> !address_strobe_n && $past(!address_strobe_n))
        else $error("data strobe asserted before address strobe");

endmodule : bus_sizer

`default_nettype wire

// file: port_model.sv
// Behavioural memory port of selectable width facing the bus sizer
`timescale 1ns/1ps
`default_nettype none
module port_model
(
    input  wire logic        core_clk,      // Bus clock
    input  wire logic [31:0] bus_addr,      // Cycle address
    input  wire logic [1:0]  size_code,     // Remaining bytes
    input  wire logic        read_write,    // High for read
    input  wire logic        data_strobe_n, // Data strobe
    input  wire logic [31:0] data_out,      // Write lanes
    input  wire logic [1:0]  width,         // 0 long, 1 word, 2 byte port
    input  wire logic [3:0]  lag,           // Wait cycles before ack
    output logic      [31:0] data_in,       // Read lanes
    output logic             ack_high_n,    // Width ack high
    output logic             ack_low_n      // Width ack low
);
    logic [7:0]  mem [0:15];
    logic [31:0] d;
    int          wait_q, pb, a, base, k;
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = 8'(i * 37 + 5);
        data_in = 32'h0;
        ack_high_n = 1'b1;
        ack_low_n = 1'b1;
        wait_q = 0;
    end
    always @(posedge core_clk)
    begin
        d = ~data_in; // Undriven lanes toggle
        pb = 4 >> width;
        a = int'(bus_addr[3:0]);
        base = a & ~(pb - 1);
        k = (size_code == 2'h0) ? 4 : int'(size_code);
        if (k > pb - (a - base))
            k = pb - (a - base);
        if (data_strobe_n)
        begin
            {ack_high_n, ack_low_n} <= 2'h3;
            wait_q <= int'(lag);
            data_in <= d;
        end
        else if (wait_q > 0)
        begin
            wait_q <= wait_q - 1;
            data_in <= d;
        end
        else if ({ack_high_n, ack_low_n} == 2'h3)
        begin
            {ack_high_n, ack_low_n} <= width;
            for (int i = 0; i < pb; i++)
            begin
                d[31 - 8 * i -: 8] = mem[base + i];
                if (!read_write && base + i >= a && base + i < a + k)
                    mem[base + i] = data_out[31 - 8 * i -: 8];
            end
            data_in <= d;
        end
    end
endmodule : port_model
`default_nettype wire

// file: byte_lane_select_decode_tb.sv
// Self-checking bench for the bus sizer against a memory port model
`timescale 1ns/1ps
`default_nettype none
module byte_lane_select_decode_tb;
    logic                   core_clk, reset, req_valid, req_ready, rsp_valid;
    logic                   sch, scl, rw, oe, addr_stb_n, data_stb_n, ackh_n, ackl_n;
    bus_sizer_pkg::op_req_s req;
    logic [31:0]            rsp_rdata, bus_addr, data_out, data_in;
    logic [1:0]             width;
    logic [3:0]             lag;
    int                     fail_count, n_tests, cyc;
    logic [7:0]             exp_mem [0:15];

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(negedge addr_stb_n)
        cyc = cyc + 1;

    bus_sizer dut_u (.core_clk(core_clk), .reset(reset), .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus_addr(bus_addr), .size_code_high(sch), .size_code_low(scl),
        .read_write(rw), .address_strobe_n(addr_stb_n), .data_strobe_n(data_stb_n), .data_out(data_out),
        .data_oe(oe), .data_in(data_in), .port_width_ack_high_n(ackh_n), .port_width_ack_low_n(ackl_n));
    port_model port_u (.core_clk(core_clk), .bus_addr(bus_addr), .size_code({sch, scl}), .read_write(rw),
        .data_strobe_n(data_stb_n), .data_out(data_out), .width(width), .lag(lag), .data_in(data_in),
        .ack_high_n(ackh_n), .ack_low_n(ackl_n));

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task test_done;
        $display("fail_count %0d n_tests %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task run_op(input logic [31:0] addr, input logic [1:0] sz, input logic wr, input logic fe, input logic [1:0] w);
        int          n, a, t, m, pb;
        logic [31:0] e;
        width = w;
        lag = 4'($urandom % 3);
        req = '{addr, sz, wr, fe, $urandom};
        cyc = 0;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        a = fe ? (int'(addr[3:0]) & ~3) : int'(addr[3:0]);
        n = (fe || sz == 2'h0) ? 4 : int'(sz);
        wr = wr && !fe;
        pb = 4 >> w;
        m = 0;
        t = a;
        while (t < a + n)
        begin
            t = t + ((pb - t % pb < a + n - t) ? pb - t % pb : a + n - t);
            m++;
        end
        e = 32'h0;
        for (int i = 0; i < n; i++)
            if (wr)
                exp_mem[a + i] = req.wdata[8 * (n - 1 - i) +: 8];
            else
                e = {e[23:0], exp_mem[a + i]};
        t = 0;
        while (rsp_valid !== 1'b1 && t < 300)
        begin
            check("ready while busy", 32'h0, 32'(req_ready));
            check("output enable", 32'(wr && !data_stb_n), 32'(oe));
            @(negedge core_clk);
            t++;
        end
        if (rsp_valid !== 1'b1)
        begin
            fail_count++;
            test_done();
        end
        check("ready after result", 32'h1, 32'(req_ready));
        check("bus cycles", 32'(m), 32'(cyc));
        if (!wr)
            check("read data", e, rsp_rdata & ((n == 4) ? 32'hffff_ffff : (32'h1 << (8 * n)) - 32'h1));
        @(negedge core_clk);
    endtask : run_op

    initial
    begin
        reset = 1'b1;
        req = '0;
        req_valid = 1'b0;
        width = 2'h0;
        lag = 4'h0;
        fail_count = 0;
        n_tests = 0;
        cyc = 0;
        void'($urandom(32'h90d86f56));
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        for (int i = 0; i < 16; i++)
            exp_mem[i] = port_u.mem[i];
        run_op(32'h1, 2'h0, 1'b1, 1'b0, 2'h1);
        for (int k = 0; k < 48; k++)
        begin
            run_op(32'(k % 4), 2'(k / 4), 1'b1, 1'b0, 2'(k / 16));
            run_op(32'(k % 4), 2'(k / 4), 1'b0, 1'b0, 2'(k / 16));
        end
        repeat (150)
            run_op(32'($urandom % 13), 2'($urandom), 1'($urandom), $urandom % 6 == 0, 2'($urandom % 3));
        for (int i = 0; i < 16; i++)
            check("memory byte", 32'(exp_mem[i]), 32'(port_u.mem[i]));
        test_done();
    end
endmodule : byte_lane_select_decode_tb
`default_nettype wire
